/* design/ssr_pkg.sv */
package ssr_pkg;

	// Register byte offsets on the AHB-Lite slave
	localparam logic [7:0] SSR_ADDR_CTRL = 8'h00;
	localparam logic [7:0] SSR_ADDR_STATUS = 8'h04;
	localparam logic [7:0] SSR_ADDR_DATA = 8'h08;
	localparam logic [7:0] SSR_ADDR_BAUD = 8'h0C;
	localparam logic [7:0] SSR_ADDR_IRQ = 8'h10;

	// Control register fields
	localparam int SSR_CTRL_PORT_EN = 0;
	localparam int SSR_CTRL_MASTER = 1;
	localparam int SSR_CTRL_SINGLE = 2;
	localparam int SSR_CTRL_CONT = 3;
	localparam int SSR_CTRL_NINE = 4;
	localparam int SSR_CTRL_WIDE = 5;
	localparam int SSR_CTRL_HSPEED = 6;

	// Status register fields
	localparam int SSR_STAT_PEND = 0;
	localparam int SSR_STAT_OVR = 1;
	localparam int SSR_STAT_NINTH = 2;
	localparam int SSR_STAT_BUSY = 3;

	// Interrupt enable register fields
	localparam int SSR_IRQ_RCV = 0;
	localparam int SSR_IRQ_PERI = 1;
	localparam int SSR_IRQ_GLB = 2;

	// Reset values
	localparam logic [7:0] SSR_CTRL_RST = 8'h00;
	localparam logic [15:0] SSR_BAUD_RST = 16'h0000;
	localparam logic [2:0] SSR_IRQ_RST = 3'h0;

	// Character and FIFO geometry
	localparam logic [3:0] SSR_BITS_NARROW = 4'h8;
	localparam logic [3:0] SSR_BITS_WIDE = 4'h9;
	localparam logic [1:0] SSR_FIFO_DEPTH = 2'h2;

	// Serial clock period is 4*(n+1) hclk, so a half period is 2*(n+1)
	localparam logic [16:0] SSR_HALF_MULT = 17'h00002;

	// Half period of the far end's own serial clock, in hclk cycles
	localparam logic [7:0] SSR_FAR_HALF = 8'h04;

	typedef enum logic {SSR_RX_IDLE, SSR_RX_SHIFT} ssr_rx_e;
	typedef enum logic {SSR_FAR_IDLE, SSR_FAR_SHIFT} ssr_far_e;

endpackage

/* design/ssr_if.sv */
`timescale 1ns/10ps
interface ssr_if;
	logic dev_clk_o;
	logic dev_clk_oe_n;
	logic dev_dat_o;
	logic dev_dat_oe_n;
	logic far_clk_o;
	logic far_clk_oe_n;
	logic far_dat_o;
	logic far_dat_oe_n;
	logic clk_line;
	logic dat_line;

	// Undriven clock idles low, undriven data is pulled high
	assign clk_line = !dev_clk_oe_n ? dev_clk_o :
		(!far_clk_oe_n ? far_clk_o : 1'b0);
	assign dat_line = !dev_dat_oe_n ? dev_dat_o :
		(!far_dat_oe_n ? far_dat_o : 1'b1);

	modport dev (
		output dev_clk_o, dev_clk_oe_n, dev_dat_o, dev_dat_oe_n,
		input clk_line, dat_line
	);
	modport far (
		output far_clk_o, far_clk_oe_n, far_dat_o, far_dat_oe_n,
		input clk_line, dat_line
	);
endinterface

/* design/ssr_brg.sv */
`timescale 1ns/10ps
module ssr_brg import ssr_pkg::*; (
	// System
	input wire logic hclk,
	input wire logic hresetn,
	// Control
	input wire logic run,
	input wire logic wide,
	input wire logic [15:0] divisor,
	// Half-period strobe
	output logic tick
);
	typedef struct packed {
		logic [16:0] cnt;
	} ssr_brg_s;

	ssr_brg_s r_ff;
	ssr_brg_s nxt_r;
	logic [16:0] limit;
	logic [16:0] half_last;

	assign limit = wide ? {1'b0, divisor} : {9'h000, divisor[7:0]};
	assign half_last = SSR_HALF_MULT * (limit + 17'h00001) - 17'h00001;
	assign tick = run && (r_ff.cnt == half_last);

	always_comb begin
		nxt_r = r_ff;
		// Restart from zero so the first half period is full length
		if (!run || tick) begin
			nxt_r.cnt = 17'h00000;
		end else begin
			nxt_r.cnt = r_ff.cnt + 17'h00001;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r_ff <= '0;
		end else begin
			r_ff <= nxt_r;
		end
	end
endmodule

/* design/ssr_far.sv */
`timescale 1ns/10ps
module ssr_far import ssr_pkg::*; (
	// System
	input wire logic hclk,
	input wire logic hresetn,
	// User side
	input wire logic drive_clock,
	input wire logic start,
	input wire logic nine,
	input wire logic [8:0] tx_data,
	output logic busy,
	output logic done,
	// Serial link
	ssr_if.far link
);
	typedef struct packed {
		ssr_far_e st;
		logic [8:0] sh;
		logic [3:0] idx;
		logic [3:0] nbits;
		logic [7:0] div;
		logic sclk;
		logic clk_prev;
		logic dat;
		logic done;
	} ssr_far_s;

	ssr_far_s r_ff;
	ssr_far_s nxt_r;
	logic rise;
	logic fall;
	logic half;

	assign rise = !r_ff.clk_prev && link.clk_line;
	assign fall = r_ff.clk_prev && !link.clk_line;
	assign half = r_ff.div == (SSR_FAR_HALF - 8'h01);

	always_comb begin
		nxt_r = r_ff;
		nxt_r.clk_prev = link.clk_line;
		nxt_r.done = 1'b0;
		case (r_ff.st)
			SSR_FAR_IDLE: begin
				nxt_r.sclk = 1'b0;
				nxt_r.div = 8'h00;
				if (start) begin
					nxt_r.st = SSR_FAR_SHIFT;
					nxt_r.sh = tx_data;
					nxt_r.idx = 4'h0;
					nxt_r.nbits = nine ? SSR_BITS_WIDE : SSR_BITS_NARROW;
				end
			end
			SSR_FAR_SHIFT: begin
				if (drive_clock) begin
					nxt_r.div = half ? 8'h00 : r_ff.div + 8'h01;
					// Receiver samples a cycle after the last fall: hold data
					if (half && r_ff.idx == r_ff.nbits) begin
						nxt_r.st = SSR_FAR_IDLE;
						nxt_r.done = 1'b1;
					end else if (half) begin
						nxt_r.sclk = !r_ff.sclk;
						if (!r_ff.sclk) begin
							nxt_r.dat = r_ff.sh[r_ff.idx];
						end
					end
				end else if (rise) begin
					nxt_r.dat = r_ff.sh[r_ff.idx];
				end
				if (drive_clock ? (half && r_ff.sclk) : fall) begin
					nxt_r.idx = r_ff.idx + 4'h1;
					if (!drive_clock && nxt_r.idx == r_ff.nbits) begin
						nxt_r.st = SSR_FAR_IDLE;
						nxt_r.done = 1'b1;
					end
				end
			end
			default: begin
				nxt_r.st = SSR_FAR_IDLE;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r_ff <= '{st: SSR_FAR_IDLE, dat: 1'b1, default: '0};
		end else begin
			r_ff <= nxt_r;
		end
	end

	assign busy = r_ff.st == SSR_FAR_SHIFT;
	assign done = r_ff.done;
	assign link.far_clk_o = r_ff.sclk;
	assign link.far_clk_oe_n = !drive_clock;
	assign link.far_dat_o = r_ff.dat;
	assign link.far_dat_oe_n = r_ff.st != SSR_FAR_SHIFT;
endmodule

/* design/ssr_dev.sv */
// Design decisions made here: the AHB-Lite register port and the address map.
`timescale 1ns/10ps
module ssr_dev import ssr_pkg::*; (
	// System
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Interrupt
	output logic irq,
	// Serial link
	ssr_if.dev link
);
	typedef struct packed {
		logic [7:0] ctrl;
		logic [15:0] baud;
		logic [2:0] irqen;
		ssr_rx_e st;
		logic [8:0] shreg;
		logic [3:0] nbit;
		logic sclk;
		logic clk_prev;
		logic [1:0][8:0] fifo;
		logic rd_ptr;
		logic [1:0] count;
		logic ovr;
		logic ovr_single;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic [31:0] rdata;
	} ssr_dev_s;

	ssr_dev_s r_ff;
	ssr_dev_s nxt_r;
	logic port_en;
	logic master;
	logic rx_go;
	logic tick;
	logic fall;
	logic complete;
	logic push;
	logic pop;
	logic [3:0] nbits;
	logic [8:0] shifted;
	logic [8:0] char_in;
	logic [8:0] top;
	logic addr_ok;

	assign port_en = r_ff.ctrl[SSR_CTRL_PORT_EN];
	assign master = port_en && r_ff.ctrl[SSR_CTRL_MASTER];
	assign rx_go = port_en && !r_ff.ovr &&
		(r_ff.ctrl[SSR_CTRL_SINGLE] || r_ff.ctrl[SSR_CTRL_CONT]);
	assign nbits = r_ff.ctrl[SSR_CTRL_NINE] ? SSR_BITS_WIDE : SSR_BITS_NARROW;
	assign top = r_ff.fifo[r_ff.rd_ptr];
	assign addr_ok = hsel && hready && htrans[1];

	ssr_brg u_brg (
		.hclk(hclk),
		.hresetn(hresetn),
		.run(master && r_ff.st == SSR_RX_SHIFT && rx_go),
		.wide(r_ff.ctrl[SSR_CTRL_WIDE]),
		.divisor(r_ff.baud),
		.tick(tick)
	);

	// Trailing edge of own or partner clock
	assign fall = master ? (tick && r_ff.sclk) :
		(r_ff.clk_prev && !link.clk_line);
	assign shifted = {link.dat_line, r_ff.shreg[8:1]};
	// Narrow characters sit one place high in the register
	assign char_in = r_ff.ctrl[SSR_CTRL_NINE] ? shifted :
		{1'b0, shifted[8:1]};
	assign complete = r_ff.st == SSR_RX_SHIFT && rx_go && fall &&
		(r_ff.nbit + 4'h1 == nbits);
	assign push = complete && r_ff.count != SSR_FIFO_DEPTH;
	assign pop = addr_ok && !hwrite && haddr[7:0] == SSR_ADDR_DATA &&
		r_ff.count != 2'h0;

	always_comb begin
		nxt_r = r_ff;
		nxt_r.clk_prev = link.clk_line;
		case (r_ff.st)
			SSR_RX_IDLE: begin
				nxt_r.sclk = 1'b0;
				nxt_r.nbit = 4'h0;
				if (rx_go) begin
					nxt_r.st = SSR_RX_SHIFT;
				end
			end
			SSR_RX_SHIFT: begin
				if (!rx_go) begin
					nxt_r.st = SSR_RX_IDLE;
					nxt_r.sclk = 1'b0;
					nxt_r.nbit = 4'h0;
				end else begin
					if (master && tick) begin
						nxt_r.sclk = !r_ff.sclk;
					end
					if (fall) begin
						nxt_r.shreg = shifted;
						nxt_r.nbit = complete ? 4'h0 : r_ff.nbit + 4'h1;
					end
				end
			end
			default: begin
				nxt_r.st = SSR_RX_IDLE;
			end
		endcase
		if (complete) begin
			nxt_r.ctrl[SSR_CTRL_SINGLE] = 1'b0;
		end
		if (push) begin
			nxt_r.fifo[r_ff.rd_ptr ^ r_ff.count[0]] = char_in;
		end
		if (pop) begin
			nxt_r.rd_ptr = !r_ff.rd_ptr;
		end
		nxt_r.count = r_ff.count + {1'b0, push} - {1'b0, pop};
		// Clear by read or by dropping continuous
		if (r_ff.ovr && (r_ff.ovr_single ? pop :
			!r_ff.ctrl[SSR_CTRL_CONT])) begin
			nxt_r.ovr = 1'b0;
		end
		if (complete && !push) begin
			nxt_r.ovr = 1'b1;
			nxt_r.ovr_single = !r_ff.ctrl[SSR_CTRL_CONT];
		end
		if (!port_en) begin
			nxt_r.st = SSR_RX_IDLE;
			nxt_r.sclk = 1'b0;
			nxt_r.nbit = 4'h0;
			nxt_r.shreg = 9'h000;
			nxt_r.count = 2'h0;
			nxt_r.rd_ptr = 1'b0;
			nxt_r.ovr = 1'b0;
			nxt_r.ovr_single = 1'b0;
		end
		// Software write wins over the hardware self-clear
		nxt_r.wr_pend = 1'b0;
		if (r_ff.wr_pend) begin
			case (r_ff.wr_addr)
				SSR_ADDR_CTRL: nxt_r.ctrl = hwdata[7:0];
				SSR_ADDR_BAUD: nxt_r.baud = hwdata[15:0];
				SSR_ADDR_IRQ: nxt_r.irqen = hwdata[2:0];
				default: nxt_r.wr_pend = 1'b0;
			endcase
		end
		if (addr_ok) begin
			nxt_r.wr_pend = hwrite;
			nxt_r.wr_addr = haddr[7:0];
			nxt_r.rdata = 32'h00000000;
			if (!hwrite) begin
				case (haddr[7:0])
					SSR_ADDR_CTRL: nxt_r.rdata[7:0] = r_ff.ctrl;
					SSR_ADDR_STATUS: begin
						nxt_r.rdata[SSR_STAT_PEND] = r_ff.count != 2'h0;
						nxt_r.rdata[SSR_STAT_OVR] = r_ff.ovr;
						nxt_r.rdata[SSR_STAT_NINTH] =
							r_ff.count != 2'h0 && top[8];
						nxt_r.rdata[SSR_STAT_BUSY] = r_ff.st == SSR_RX_SHIFT;
					end
					SSR_ADDR_DATA: nxt_r.rdata[7:0] =
						r_ff.count != 2'h0 ? top[7:0] : 8'h00;
					SSR_ADDR_BAUD: nxt_r.rdata[15:0] = r_ff.baud;
					SSR_ADDR_IRQ: nxt_r.rdata[2:0] = r_ff.irqen;
					default: nxt_r.rdata = 32'h00000000;
				endcase
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r_ff <= '{ctrl: SSR_CTRL_RST, baud: SSR_BAUD_RST,
				irqen: SSR_IRQ_RST, st: SSR_RX_IDLE, default: '0};
		end else begin
			r_ff <= nxt_r;
		end
	end

	// Writes take one wait state so a following read sees new values
	assign hreadyout = !r_ff.wr_pend;
	assign hresp = 1'b0;
	assign hrdata = r_ff.rdata;
	// All three enables gate the pending flag
	assign irq = r_ff.count != 2'h0 && r_ff.irqen[SSR_IRQ_RCV] &&
		r_ff.irqen[SSR_IRQ_PERI] && r_ff.irqen[SSR_IRQ_GLB];
	assign link.dev_clk_o = r_ff.sclk;
	assign link.dev_clk_oe_n = !master;
	assign link.dev_dat_o = 1'b0;
	assign link.dev_dat_oe_n = 1'b1;
endmodule

/* tb/ssr_properties.sv */
`timescale 1ns/10ps
module ssr_properties (
	// System
	input wire logic hclk,
	input wire logic hresetn,
	// Link
	input wire logic dev_clk_o,
	input wire logic dev_clk_oe_n,
	input wire logic dev_dat_o,
	input wire logic dev_dat_oe_n,
	input wire logic far_clk_o,
	input wire logic far_clk_oe_n,
	input wire logic far_dat_o,
	input wire logic far_dat_oe_n,
	input wire logic clk_line,
	input wire logic dat_line
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	dat_released_a: assert property (dev_dat_oe_n)
		else $error("device drove the data pin");
	slave_clk_off_a: assert property (
		!far_clk_oe_n |-> dev_clk_oe_n)
		else $error("device drove clock while far end clocks");
	one_clk_drv_a: assert property (
		dev_clk_oe_n || far_clk_oe_n)
		else $error("two drivers on the clock line");
	fall_stable_a: assert property (
		$fell(clk_line) && !far_dat_oe_n |-> $stable(far_dat_o))
		else $error("data moved on the trailing edge");
	dev_low_a: assert property (
		$fell(dev_clk_o) && !dev_clk_oe_n |-> !dev_clk_o [*4])
		else $error("master clock low phase too short");
	dev_high_a: assert property (
		$rose(dev_clk_o) && !dev_clk_oe_n |-> ##4 !dev_clk_o)
		else $error("master clock high phase too long");
	far_high_a: assert property (
		$rose(far_clk_o) && !far_clk_oe_n |->
		far_clk_o [*4] ##1 !far_clk_o)
		else $error("far clock high phase wrong");
	far_low_a: assert property (
		$fell(far_clk_o) && !far_clk_oe_n |-> !far_clk_o [*4])
		else $error("far clock low phase too short");
endmodule

/* tb/tb.sv */
`timescale 1ns/10ps
module tb import ssr_pkg::*;;
	localparam logic [31:0] PE = 32'h1 << SSR_CTRL_PORT_EN;
	localparam logic [31:0] MS = 32'h1 << SSR_CTRL_MASTER;
	localparam logic [31:0] S = 32'h1 << SSR_CTRL_SINGLE;
	localparam logic [31:0] C = 32'h1 << SSR_CTRL_CONT;
	localparam logic [31:0] N = 32'h1 << SSR_CTRL_NINE;
	localparam logic [31:0] PD = 32'h1 << SSR_STAT_PEND;
	localparam logic [31:0] OV = 32'h1 << SSR_STAT_OVR;
	localparam logic [31:0] N9 = 32'h1 << SSR_STAT_NINTH;
	localparam logic [31:0] W = 32'h1 << SSR_CTRL_WIDE;
	localparam logic [31:0] BZ = 32'h1 << SSR_STAT_BUSY;
	localparam int LIMIT = 20000;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
	logic [31:0] haddr, hwdata, hrdata, q, rq;
	logic [1:0] htrans;
	logic drive_clock, start, nine, busy, done, clk_q;
	logic [8:0] tx_data;
	int n_fail, checks, n_rise, b, b16, cycles;

	ssr_if u_ssr_if();
	assign hready = hreadyout;
	ssr_dev u_ssr_dev (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .irq(irq), .link(u_ssr_if));
	ssr_far u_ssr_far (.hclk(hclk), .hresetn(hresetn),
		.drive_clock(drive_clock), .start(start), .nine(nine),
		.tx_data(tx_data), .busy(busy), .done(done), .link(u_ssr_if));
	ssr_properties u_chk (.hclk(hclk), .hresetn(hresetn),
		.dev_clk_o(u_ssr_if.dev_clk_o), .dev_clk_oe_n(u_ssr_if.dev_clk_oe_n),
		.dev_dat_o(u_ssr_if.dev_dat_o), .dev_dat_oe_n(u_ssr_if.dev_dat_oe_n),
		.far_clk_o(u_ssr_if.far_clk_o), .far_clk_oe_n(u_ssr_if.far_clk_oe_n),
		.far_dat_o(u_ssr_if.far_dat_o), .far_dat_oe_n(u_ssr_if.far_dat_oe_n),
		.clk_line(u_ssr_if.clk_line), .dat_line(u_ssr_if.dat_line));

	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end

	task report_and_stop;
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Rising edges of the resolved clock, the count the single, nine, continuous and slave tests lean on
	always @(posedge hclk) begin
		clk_q <= u_ssr_if.clk_line;
		if (u_ssr_if.clk_line === 1'b1 && clk_q === 1'b0)
			n_rise <= n_rise + 1;
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			n_fail = n_fail + 1;
			report_and_stop;
		end
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks = checks + 1;
		if (seen !== exp) begin
			n_fail = n_fail + 1;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Ready is read mid-cycle, where it is settled, then the edge is taken
	task rdy;
		@(negedge hclk);
		while (hreadyout !== 1'b1)
			@(negedge hclk);
		rq = hrdata;
		@(posedge hclk);
	endtask

	task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h0, a};
		rdy;
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= d;
		rdy;
		q = rq;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		ahb(1'b1, a, d);
	endtask

	task rd(input logic [7:0] a);
		ahb(1'b0, a, 32'h0);
	endtask

	task do_reset;
		hresetn <= 1'b0;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
	endtask

	// Entered just after an edge, so start lands before the next rise
	task fstart(input logic [8:0] d, input logic nb);
		tx_data <= d;
		nine <= nb;
		start <= 1'b1;
		@(posedge hclk);
		start <= 1'b0;
	endtask

	task wait_done;
		@(negedge hclk);
		while (done !== 1'b1)
			@(negedge hclk);
		@(posedge hclk);
	endtask

	task rx_one(input logic [8:0] d, input logic nb, input logic [31:0] c);
		fstart(d, nb);
		wr(SSR_ADDR_CTRL, c);
		wait_done;
		repeat (3) @(posedge hclk);
	endtask

	task t_regs;
		rd(SSR_ADDR_CTRL);
		chk(q, {24'h0, SSR_CTRL_RST});
		rd(SSR_ADDR_BAUD);
		chk(q, {16'h0, SSR_BAUD_RST});
		rd(SSR_ADDR_IRQ);
		chk(q, {29'h0, SSR_IRQ_RST});
		wr(8'h14, 32'hFFFFFFFF);
		rd(8'h14);
		chk(q, 32'h0);
		chk({31'h0, hresp}, 32'h0);
		wr(SSR_ADDR_BAUD, 32'h1);
		rd(SSR_ADDR_BAUD);
		chk(q, 32'h1);
		wr(SSR_ADDR_CTRL, PE | MS);
		$display("test regs done");
	endtask

	task t_single;
		b = n_rise;
		rx_one(9'h0A5, 1'b0, PE | MS | S | W);
		chk(n_rise - b, 32'h8);
		rd(SSR_ADDR_CTRL);
		chk(q & S, 32'h0);
		rd(SSR_ADDR_STATUS);
		chk(q & PD, PD);
		chk({31'h0, irq}, 32'h0);
		wr(SSR_ADDR_IRQ, 32'h7);
		chk({31'h0, irq}, 32'h1);
		wr(SSR_ADDR_IRQ, 32'h3);
		chk({31'h0, irq}, 32'h0);
		rd(SSR_ADDR_DATA);
		chk(q, 32'hA5);
		rd(SSR_ADDR_STATUS);
		chk(q & PD, 32'h0);
		$display("test single done");
	endtask

	task t_fifo;
		rx_one(9'h011, 1'b0, PE | MS | S);
		rx_one(9'h022, 1'b0, PE | MS | S);
		rx_one(9'h033, 1'b0, PE | MS | S);
		rd(SSR_ADDR_STATUS);
		chk(q & (PD | OV), PD | OV);
		rd(SSR_ADDR_DATA);
		chk(q, 32'h11);
		rd(SSR_ADDR_STATUS);
		chk(q & (PD | OV), PD);
		rd(SSR_ADDR_DATA);
		chk(q, 32'h22);
		rd(SSR_ADDR_STATUS);
		chk(q & PD, 32'h0);
		$display("test fifo done");
	endtask

	task t_nine;
		b = n_rise;
		wr(SSR_ADDR_BAUD, 32'h101);
		rx_one(9'h15A, 1'b1, PE | MS | S | N);
		chk(n_rise - b, 32'h9);
		rd(SSR_ADDR_STATUS);
		chk(q & N9, N9);
		rd(SSR_ADDR_DATA);
		chk(q, 32'h5A);
		$display("test nine done");
	endtask

	task t_cont;
		b = n_rise;
		fstart(9'h03C, 1'b0);
		wr(SSR_ADDR_CTRL, PE | MS | S | C);
		wait_done;
		fstart(9'h0C3, 1'b0);
		wait_done;
		b16 = n_rise - b;
		fstart(9'h0FF, 1'b0);
		chk(b16, 32'h10);
		rd(SSR_ADDR_CTRL);
		chk(q & (S | C), C);
		while (n_rise - b < 19)
			@(posedge hclk);
		// Abort in a low phase so the far end has no edge to race
		while (u_ssr_if.clk_line !== 1'b0)
			@(negedge hclk);
		wr(SSR_ADDR_CTRL, PE | MS);
		b = n_rise;
		repeat (40) @(posedge hclk);
		chk(n_rise - b, 32'h0);
		rd(SSR_ADDR_DATA);
		chk(q, 32'h3C);
		rd(SSR_ADDR_DATA);
		chk(q, 32'hC3);
		rd(SSR_ADDR_STATUS);
		chk(q & PD, 32'h0);
		// Far end still waits for the lost bits; only reset frees it
		do_reset;
		$display("test continuous done");
	endtask

	task t_slave;
		wr(SSR_ADDR_CTRL, PE | C);
		drive_clock <= 1'b1;
		b = n_rise;
		fstart(9'h069, 1'b0);
		@(negedge hclk);
		chk({31'h0, busy}, 32'h1);
		wait_done;
		repeat (3) @(posedge hclk);
		chk({31'h0, busy}, 32'h0);
		chk(n_rise - b, 32'h8);
		chk({31'h0, u_ssr_if.dev_clk_oe_n}, 32'h1);
		rd(SSR_ADDR_STATUS);
		chk(q & (PD | BZ), PD | BZ);
		rd(SSR_ADDR_DATA);
		chk(q, 32'h69);
		drive_clock <= 1'b0;
		$display("test slave done");
	endtask

	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hwdata = 32'h0;
		drive_clock = 1'b0;
		start = 1'b0;
		nine = 1'b0;
		tx_data = 9'h000;
		clk_q = 1'b0;
		n_fail = 0;
		checks = 0;
		n_rise = 0;
		cycles = 0;
		do_reset;
		t_regs;
		t_single;
		t_fifo;
		t_nine;
		t_cont;
		t_slave;
		report_and_stop;
	end
endmodule
